// ---- design/rsp_cmd_port.sv ----
// Purpose: Two-wire target port holding regulator control settings and telemetry.
// Assumes: scl and sda inputs are synchronous to sys_clk and slow against it.
// Notes: Open-drain pins drive low only; the wire level comes from outside.
// Notes on behaviour
// [RULE1] Answer only addresses 80h write, 81h read.
// [RULE2] Address bit 0 chooses write or read.
// [RULE3] Packet error check supported; alert line provided.
// [RULE4] Host reads using repeated start, no stop.
// [RULE5] Writes accepted 11ms after reset, enable high.
// [RULE6] D4h bit 0 droop, strap default on enable.
// [RULE7] D8h bit 0 overvoltage select, resets zero.
// [RULE8] DAh voltage code, boot code strap default.
// [RULE9] Voltage code write carries one data byte.
// [RULE10] DBh signed offset in code steps, resets 00h.
// [RULE11] Priority 00h CPU sum; 01h host offset.
// [RULE12] Priority 02h: CPU state, offset only acknowledged.
// [RULE13] Priority 03h: host code plus host offset.
// [RULE14] CPU bus commands always acknowledged.
// [RULE15] CPU values used until host write succeeds.
// [RULE16] Host writes priority before code or offset.
// [RULE17] 8Bh returns output voltage, two bytes.
// [RULE18] 8Ch returns output current, two bytes.
// [RULE19] Bad check byte discards the write.
// [RULE20] Unused control bits ignored, read zero.
`timescale 1ns/1ps
module rsp_cmd_port #(
    parameter int unsigned PWRUP_CYC = rsp_pkg::PWRUP_CYC_DFLT
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic alert_out,
    output logic alert_oe,
    input wire logic regulator_enable_input,
    input wire logic strap_droop_en,
    input wire logic [7:0] strap_boot_voltage,
    input wire logic [7:0] cpu_bus_voltage_code,
    input wire logic [7:0] cpu_bus_voltage_offset,
    input wire logic [7:0] output_current_code,
    input wire logic cpu_cmd_valid,
    output logic cpu_cmd_ack,
    output logic cpu_vid_apply_en,
    output logic cpu_ps_decay_apply_en,
    output logic cpu_offset_apply_en,
    output logic [7:0] dac_target,
    output logic droop_en,
    output logic ov_fixed_sel
);
    import rsp_pkg::*;

    rsp_state_t state_r;
    logic scl_d_r, sda_d_r, en_d_r;
    logic [3:0] bit_cnt_r;
    logic ack_slot_r, sda_oe_r, master_nack_r;
    logic [7:0] shift_r, cmd_r, data0_r, tx_r;
    logic [1:0] wcnt_r, tx_idx_r;
    logic pec_ok_r, pec_fault_r;
    logic [TMR_W-1:0] tmr_r;
    logic por_done_r;
    logic droop_r, ov_sel_r, code_valid_r, offs_valid_r;
    logic [1:0] prio_r;
    logic [7:0] vcode_r, voffs_r, dac_r, dac_nxt, tx_nxt, rd_lo;
    logic scl_rise, scl_fall, start_c, stop_c, byte_done, en_rise, write_ok, commit, pec_bad;
    logic two_byte, sel_code, sel_offs;
    logic [7:0] sv_sum;

    rsp_pec_if pec_bus ();

    rsp_pec u_pec (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pec(pec_bus)
    );

    // Bus conditions seen from the delayed copies of the pins.
    assign scl_rise = scl_in && !scl_d_r;
    assign scl_fall = !scl_in && scl_d_r;
    assign start_c = scl_in && scl_d_r && sda_d_r && !sda_in;
    assign stop_c = scl_in && scl_d_r && !sda_d_r && sda_in;
    assign byte_done = scl_fall && !ack_slot_r && (bit_cnt_r == BITS_PER_BYTE)
                       && (state_r != ST_IDLE);
    assign en_rise = regulator_enable_input && !en_d_r;
    assign write_ok = por_done_r && regulator_enable_input; // RULE5
    // One data byte commits plainly; a second byte is the check byte.
    assign commit = stop_c && (state_r == ST_WDATA) && write_ok
                    && ((wcnt_r == 2'd1) || ((wcnt_r == 2'd2) && pec_ok_r)); // RULE9 RULE19
    assign pec_bad = stop_c && (state_r == ST_WDATA) && (wcnt_r == 2'd2) && !pec_ok_r; // RULE3

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            en_d_r <= 1'b0;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            en_d_r <= regulator_enable_input;
        end
    end

    // Write lockout timer runs once from reset release.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_r <= '0;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            tmr_r <= tmr_r + 1'b1;
            por_done_r <= (tmr_r == TMR_W'(PWRUP_CYC - 1)); // RULE5
        end
    end

    // Every byte on the wire, sent or received, feeds the check value.
    // A repeated start keeps the value so a read covers both halves.
    assign pec_bus.clr = start_c && (state_r == ST_IDLE); // RULE4
    assign pec_bus.feed = byte_done;
    assign pec_bus.data = shift_r;

    // Read data: lone bytes and the two-byte telemetry words.
    assign two_byte = (cmd_r == CMD_VOUT_RD) || (cmd_r == CMD_IOUT_RD);
    always_comb begin
        unique case (cmd_r)
            CMD_VOUT_RD: rd_lo = dac_r; // RULE17
            CMD_IOUT_RD: rd_lo = output_current_code; // RULE18
            CMD_DROOP: rd_lo = {7'h00, droop_r}; // RULE20
            CMD_PRIO: rd_lo = {6'h00, prio_r};
            CMD_OV_SEL: rd_lo = {7'h00, ov_sel_r};
            CMD_VCODE: rd_lo = vcode_r;
            CMD_VOFFS: rd_lo = voffs_r;
            default: rd_lo = BYTE_ZERO;
        endcase
        unique case (tx_idx_r)
            2'd0: tx_nxt = rd_lo;
            2'd1: tx_nxt = two_byte ? BYTE_ZERO : pec_bus.crc; // RULE3
            2'd2: tx_nxt = two_byte ? pec_bus.crc : BYTE_IDLE;
            default: tx_nxt = BYTE_IDLE;
        endcase
    end

    // Protocol engine: bits in on rising scl, drive changes on falling scl.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sda_oe_r <= 1'b0;
            master_nack_r <= 1'b0;
            shift_r <= BYTE_ZERO;
            cmd_r <= BYTE_ZERO;
            data0_r <= BYTE_ZERO;
            tx_r <= BYTE_ZERO;
            wcnt_r <= 2'd0;
            tx_idx_r <= 2'd0;
            pec_ok_r <= 1'b0;
        end else if (start_c) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (state_r != ST_IDLE) begin
            if (scl_rise && !ack_slot_r) begin
                shift_r <= {shift_r[6:0], sda_in};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_rise) begin
                master_nack_r <= sda_in;
            end else if (byte_done) begin
                ack_slot_r <= 1'b1;
                sda_oe_r <= 1'b1;
                unique case (state_r)
                    ST_ADDR: begin
                        if (shift_r[7:1] != ADDR_WR[7:1]) begin
                            state_r <= ST_IDLE; // RULE1
                            sda_oe_r <= 1'b0;
                        end else if (shift_r[DIR_BIT]) begin
                            state_r <= ST_RDATA; // RULE2
                            tx_idx_r <= 2'd0;
                        end else begin
                            state_r <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        cmd_r <= shift_r;
                        state_r <= ST_WDATA;
                        wcnt_r <= 2'd0;
                    end
                    ST_WDATA: begin
                        if (wcnt_r == 2'd0) begin
                            data0_r <= shift_r;
                        end
                        if (wcnt_r == 2'd1) begin
                            pec_ok_r <= (shift_r == pec_bus.crc); // RULE19
                        end
                        if (wcnt_r != 2'd3) begin
                            wcnt_r <= wcnt_r + 2'd1;
                        end
                    end
                    ST_RDATA: begin
                        sda_oe_r <= 1'b0;
                        tx_idx_r <= (tx_idx_r == 2'd3) ? tx_idx_r : tx_idx_r + 2'd1;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end else if (scl_fall && ack_slot_r) begin
                ack_slot_r <= 1'b0;
                bit_cnt_r <= 4'h0;
                if (state_r == ST_RDATA && master_nack_r) begin
                    state_r <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end else if (state_r == ST_RDATA) begin
                    tx_r <= tx_nxt;
                    sda_oe_r <= !tx_nxt[7];
                end else begin
                    sda_oe_r <= 1'b0;
                end
            end else if (scl_fall && state_r == ST_RDATA) begin
                sda_oe_r <= !tx_r[3'(4'd7 - bit_cnt_r)];
            end
        end
    end

    // Control settings; the enable edge reloads the strap defaults.
    // Writes are stored even when priority keeps them out of the target.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            droop_r <= 1'b0;
            prio_r <= PRIO_RST;
            ov_sel_r <= OV_SEL_RST; // RULE7
            vcode_r <= BYTE_ZERO;
            voffs_r <= VOFFS_RST; // RULE10
            code_valid_r <= 1'b0;
            offs_valid_r <= 1'b0;
        end else if (en_rise) begin
            droop_r <= strap_droop_en; // RULE6
            vcode_r <= strap_boot_voltage; // RULE8
            code_valid_r <= 1'b0; // RULE15
            offs_valid_r <= 1'b0;
        end else if (commit) begin
            unique case (cmd_r)
                CMD_DROOP: droop_r <= data0_r[0]; // RULE20
                CMD_PRIO: prio_r <= data0_r[1:0];
                CMD_OV_SEL: ov_sel_r <= data0_r[0];
                CMD_VCODE: begin
                    vcode_r <= data0_r;
                    code_valid_r <= 1'b1;
                end
                CMD_VOFFS: begin
                    voffs_r <= data0_r;
                    offs_valid_r <= 1'b1;
                end
                default: droop_r <= droop_r;
            endcase
        end
    end

    // Alert stays low from a failed check until a write commits.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pec_fault_r <= 1'b0;
        end else if (pec_bad) begin
            pec_fault_r <= 1'b1; // RULE3
        end else if (commit) begin
            pec_fault_r <= 1'b0;
        end
    end

    // Final target; signed offset wraps in eight bits like the code table.
    assign sv_sum = cpu_bus_voltage_code + cpu_bus_voltage_offset;
    assign sel_offs = (prio_r != PRIO_CPU) && offs_valid_r; // RULE11 RULE12 RULE15
    assign sel_code = (prio_r == PRIO_HOST_ALL) && code_valid_r; // RULE13
    always_comb begin
        dac_nxt = (sel_code ? vcode_r : cpu_bus_voltage_code)
                  + (sel_offs ? voffs_r : cpu_bus_voltage_offset);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_r <= BYTE_ZERO;
        end else begin
            dac_r <= dac_nxt;
        end
    end

    // Gates toward the CPU bus logic; acknowledgement never depends on them.
    assign cpu_cmd_ack = cpu_cmd_valid; // RULE14
    assign cpu_vid_apply_en = (prio_r != PRIO_HOST_ALL); // RULE13
    assign cpu_ps_decay_apply_en = (prio_r == PRIO_CPU) || (prio_r == PRIO_HOST_OFFS); // RULE12
    assign cpu_offset_apply_en = cpu_ps_decay_apply_en;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign alert_out = 1'b0;
    assign alert_oe = pec_fault_r;
    assign dac_target = dac_r;
    assign droop_en = droop_r;
    assign ov_fixed_sel = ov_sel_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_addr_byte;
        byte_done && (state_r == ST_ADDR);
    endsequence
    sequence s_bad_check;
        pec_bad && !commit;
    endsequence

    a_addr_reject: assert property (s_addr_byte ##0 (shift_r[7:1] != 7'h40) |=> !sda_oe) // RULE1
        else $error("Foreign address acknowledged.");
    a_dir_read: assert property ( // RULE2
        s_addr_byte ##0 (shift_r == 8'h81) |=> state_r == ST_RDATA)
        else $error("Read address did not enter read state.");
    a_check_alert: assert property (s_bad_check |=> alert_oe ##1 alert_oe) // RULE3
        else $error("Alert not raised after bad check byte.");
    a_bad_discard: assert property (s_bad_check |=> $stable(voffs_r) && $stable(prio_r)) // RULE19
        else $error("Write with bad check byte changed a register.");
    a_early_lock: assert property ( // RULE5
        stop_c && !write_ok && !en_rise |=> $stable(vcode_r) && $stable(ov_sel_r))
        else $error("Write accepted before lockout ended.");
    a_droop_strap: assert property (en_rise |=> droop_en == $past(strap_droop_en)) // RULE6
        else $error("Droop default not loaded from strap.");
    a_prio_cpu: assert property ( // RULE11
        prio_r == 2'h0 && $stable(sv_sum) |=> dac_target == $past(sv_sum))
        else $error("Priority 00h target is not the CPU sum.");
    a_prio_full: assert property ( // RULE13
        prio_r == 2'h3 |-> !cpu_vid_apply_en && !cpu_offset_apply_en)
        else $error("Priority 03h still applies CPU settings.");
    a_cpu_ack: assert property (cpu_cmd_ack == cpu_cmd_valid) // RULE14
        else $error("CPU command not acknowledged.");
    a_unused_zero: assert property ( // RULE20
        commit && cmd_r == 8'hD6 |=> prio_r == $past(data0_r[1:0]))
        else $error("Priority field not taken from low bits.");
endmodule : rsp_cmd_port

// ---- include/rsp_pkg.sv ----
// Purpose: Shared constants for the regulator two-wire command port.
// Assumes: 200 MHz system clock; pins sampled as synchronous inputs.
// Notes: Command codes double as register offsets on the two-wire bus.
package rsp_pkg;
    // Target address, write and read forms; bit 0 carries the direction.
    localparam logic [7:0] ADDR_WR = 8'h80;
    localparam logic [7:0] ADDR_RD = 8'h81;
    localparam int DIR_BIT = 0;
    // Command codes.
    localparam logic [7:0] CMD_VOUT_RD = 8'h8B;
    localparam logic [7:0] CMD_IOUT_RD = 8'h8C;
    localparam logic [7:0] CMD_DROOP = 8'hD4;
    localparam logic [7:0] CMD_PRIO = 8'hD6;
    localparam logic [7:0] CMD_OV_SEL = 8'hD8;
    localparam logic [7:0] CMD_VCODE = 8'hDA;
    localparam logic [7:0] CMD_VOFFS = 8'hDB;
    // Values after reset, and the zero and idle data bytes.
    localparam logic [1:0] PRIO_RST = 2'h0;
    localparam logic OV_SEL_RST = 1'b0;
    localparam logic [7:0] VOFFS_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_IDLE = 8'hFF;
    // Priority encodings.
    localparam logic [1:0] PRIO_CPU = 2'h0;
    localparam logic [1:0] PRIO_HOST_OFFS = 2'h1;
    localparam logic [1:0] PRIO_OC_OFFS = 2'h2;
    localparam logic [1:0] PRIO_HOST_ALL = 2'h3;
    // Power-up write lockout.
    localparam int unsigned PWRUP_MS = 11;
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned PWRUP_CYC_DFLT = PWRUP_MS * CLK_KHZ;
    localparam int TMR_W = 22;
    // Packet error check polynomial, x^8 + x^2 + x + 1.
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [7:0] PEC_INIT = 8'h00;
    // Bit counter value that marks a complete byte.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Protocol engine states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_CMD = 5'h04,
        ST_WDATA = 5'h08,
        ST_RDATA = 5'h10
    } rsp_state_t;
endpackage : rsp_pkg

// ---- include/rsp_pec_if.sv ----
// Purpose: Carries bytes into the packet error check engine and its result back.
// Assumes: One clock domain.
// Notes: The engine updates one whole byte per feed pulse.
`timescale 1ns/1ps
interface rsp_pec_if;
    logic clr;
    logic feed;
    logic [7:0] data;
    logic [7:0] crc;
    modport calc (input clr, input feed, input data, output crc);
    modport user (output clr, output feed, output data, input crc);
endinterface : rsp_pec_if

// ---- design/rsp_pec.sv ----
// Purpose: Running CRC-8 over every byte of a two-wire transaction.
// Assumes: clr and feed never arrive in the same cycle.
// Notes: Whole byte folded in one cycle to keep up with any bus rate.
`timescale 1ns/1ps
module rsp_pec (
    input wire logic sys_clk,
    input wire logic rst_b,
    rsp_pec_if.calc pec
);
    import rsp_pkg::*;

    logic [7:0] crc_r;

    // Folds one byte into the running value, most significant bit first.
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] v;
        v = c ^ d;
        for (int i = 0; i < 8; i++) begin
            v = v[7] ? ({v[6:0], 1'b0} ^ PEC_POLY) : {v[6:0], 1'b0};
        end
        return v;
    endfunction : crc_byte

    // The running value restarts at each new transaction.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_r <= PEC_INIT;
        end else if (pec.clr) begin
            crc_r <= PEC_INIT;
        end else if (pec.feed) begin
            crc_r <= crc_byte(crc_r, pec.data);
        end
    end

    assign pec.crc = crc_r;
endmodule : rsp_pec

// ---- verif/rsp_host_model.sv ----
// Purpose: Bus master model that drives the two-wire port of the command block.
// Assumes: Open-drain data wire with a pull-up; the model only ever pulls low.
// Notes: Half a bus bit lasts four system clocks, slow against the target.
`timescale 1ns/1ps
module rsp_host_model (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    logic [7:0] crc;

    // Bus idles with scl driven high and sda released, so its pull-up holds it high.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        crc = 8'h00;
    end

    // Running check byte over every byte on the wire, MSB first.
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction : crc_step

    task automatic half();
        repeat (4) @(posedge sys_clk);
    endtask : half

    // A start clears the check byte; a repeated start keeps it running.
    task automatic bus_start(input logic fresh);
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
        if (fresh) begin
            crc = 8'h00;
        end
    endtask : bus_start

    task automatic stop();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask : stop

    // Data changes only while the clock is low; sampled late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
    endtask : bit_io

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, ack);
        crc = crc_step(crc, b);
    endtask : put_byte

    task automatic get_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(nack, r);
        crc = crc_step(crc, b);
    endtask : get_byte
endmodule : rsp_host_model

// ---- verif/tb_rsp_cmd_port.sv ----
// Purpose: Self-checking bench for the regulator two-wire command port.
// Assumes: Lockout shortened to LOCK_CYC cycles so the run stays short.
// Notes: Expected targets are worked out by hand from the priority table.
`timescale 1ns/1ps
module tb_rsp_cmd_port;
    import rsp_pkg::*;
    localparam int unsigned LOCK_CYC = 600;
    logic sys_clk, rst_b, scl_in, sda_in, sda_out, sda_oe, alert_out, alert_oe;
    logic regulator_enable_input, strap_droop_en, cpu_cmd_valid, cpu_cmd_ack;
    logic [7:0] strap_boot_voltage, cpu_bus_voltage_code, cpu_bus_voltage_offset;
    logic [7:0] output_current_code, dac_target;
    logic cpu_vid_apply_en, cpu_ps_decay_apply_en, cpu_offset_apply_en;
    logic droop_en, ov_fixed_sel, host_pull;
    int bad_count = 0;
    int n_compared = 0;

    // Wired-AND of both parties with a pull-up when nobody drives.
    assign sda_in = ~host_pull & (sda_oe ? sda_out : 1'b1);

    rsp_cmd_port #(.PWRUP_CYC(LOCK_CYC)) dut (.sys_clk, .rst_b, .scl_in, .sda_in,
        .sda_out, .sda_oe, .alert_out, .alert_oe, .regulator_enable_input,
        .strap_droop_en, .strap_boot_voltage, .cpu_bus_voltage_code,
        .cpu_bus_voltage_offset, .output_current_code, .cpu_cmd_valid, .cpu_cmd_ack,
        .cpu_vid_apply_en, .cpu_ps_decay_apply_en, .cpu_offset_apply_en, .dac_target,
        .droop_en, .ov_fixed_sel);

    rsp_host_model host (.sys_clk(sys_clk), .sda(sda_in), .scl(scl_in),
        .sda_pull(host_pull));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Check mode: 0 sends no check byte, 1 a correct one, 2 a corrupted one.
    task automatic reg_write(input logic [7:0] cmd, input logic [7:0] val, input int pec);
        logic a;
        host.bus_start(1'b1);
        host.put_byte(ADDR_WR, a);
        check("write address ack", 16'(a), 16'h0000);
        host.put_byte(cmd, a);
        host.put_byte(val, a);
        if (pec == 1) host.put_byte(host.crc, a);
        if (pec == 2) host.put_byte(~host.crc, a);
        host.stop();
        repeat (4) @(posedge sys_clk);
    endtask : reg_write

    // Command, then repeated start with no stop between, then n bytes and the check byte.
    task automatic reg_read(input logic [7:0] cmd, input int n, input logic [15:0] exp,
            input string what);
        logic a;
        logic [7:0] b;
        logic [7:0] c;
        logic [15:0] v;
        v = 16'h0000;
        host.bus_start(1'b1);
        host.put_byte(ADDR_WR, a);
        host.put_byte(cmd, a);
        host.bus_start(1'b0);
        host.put_byte(ADDR_RD, a);
        check("read address ack", 16'(a), 16'h0000);
        for (int i = 0; i < n; i++) begin
            host.get_byte(1'b0, b);
            v[8*i +: 8] = b;
        end
        c = host.crc;
        host.get_byte(1'b1, b);
        host.stop();
        check(what, v, exp);
        check("read check byte", {8'h00, b}, {8'h00, c});
    endtask : reg_read

    // Bound well above the roughly 10000 cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic a;
        logic [7:0] dac_exp [4];
        logic [2:0] en_exp [4];
        dac_exp = '{8'h52, 8'h4E, 8'h4E, 8'h6E};
        en_exp = '{3'h7, 3'h7, 3'h4, 3'h0};
        rst_b = 1'b0;
        regulator_enable_input = 1'b0;
        strap_droop_en = 1'b1;
        strap_boot_voltage = 8'h3C;
        cpu_bus_voltage_code = 8'h50;
        cpu_bus_voltage_offset = 8'h02;
        output_current_code = 8'hC5;
        cpu_cmd_valid = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        regulator_enable_input <= 1'b1;
        reg_write(CMD_OV_SEL, 8'h01, 1);
        reg_read(CMD_OV_SEL, 1, 16'h0000, "write inside lockout");
        repeat (LOCK_CYC) @(posedge sys_clk);
        regulator_enable_input <= 1'b0;
        reg_write(CMD_OV_SEL, 8'h01, 1);
        reg_read(CMD_OV_SEL, 1, 16'h0000, "write with enable low");
        regulator_enable_input <= 1'b1;
        reg_read(CMD_PRIO, 1, 16'h0000, "priority reset");
        reg_read(CMD_VOFFS, 1, 16'h0000, "offset reset");
        reg_read(CMD_DROOP, 1, 16'h0001, "droop strap");
        reg_read(CMD_VCODE, 1, 16'h003C, "boot code");
        check("droop pin", 16'(droop_en), 16'h0001);
        host.bus_start(1'b1);
        host.put_byte(8'hA0, a);
        host.stop();
        check("foreign address nack", 16'(a), 16'h0001);
        reg_write(CMD_OV_SEL, 8'hFF, 0);
        reg_read(CMD_OV_SEL, 1, 16'h0001, "ov select");
        check("ov pin", 16'(ov_fixed_sel), 16'h0001);
        reg_write(CMD_PRIO, 8'hFF, 1);
        reg_read(CMD_PRIO, 1, 16'h0003, "priority bits");
        check("target before host write", {8'h00, dac_target}, 16'h0052);
        reg_write(CMD_VCODE, 8'h70, 1);
        reg_write(CMD_VOFFS, 8'hFE, 1);
        for (int p = 0; p < 4; p++) begin
            reg_write(CMD_PRIO, 8'(p), 1);
            cpu_cmd_valid <= p[0];
            @(posedge sys_clk);
            #1;
            check("dac target", {8'h00, dac_target}, {8'h00, dac_exp[p]});
            check("apply enables", {13'h0000, cpu_vid_apply_en, cpu_ps_decay_apply_en,
                cpu_offset_apply_en}, {13'h0000, en_exp[p]});
            check("cpu ack", 16'(cpu_cmd_ack), 16'(p[0]));
        end
        reg_read(CMD_VOUT_RD, 2, 16'h006E, "voltage telemetry");
        reg_read(CMD_IOUT_RD, 2, 16'h00C5, "current telemetry");
        reg_read(CMD_VCODE, 1, 16'h0070, "host code");
        reg_write(CMD_VOFFS, 8'h11, 2);
        check("alert on bad check", 16'(alert_oe), 16'h0001);
        check("alert level", 16'(alert_out), 16'h0000);
        reg_read(CMD_VOFFS, 1, 16'h00FE, "offset kept");
        reg_write(CMD_DROOP, 8'h00, 1);
        check("alert cleared", 16'(alert_oe), 16'h0000);
        check("droop off", 16'(droop_en), 16'h0000);
        end_of_test();
    end
endmodule : tb_rsp_cmd_port
